/* verilog/eiprl_top.sv */
// Top of the external interrupt, priority and latency logic with APB slave.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
module eiprl_top
#(
    parameter int NSRC = 8,
    parameter int IW = 3
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_a_input,
    input wire logic ext_irq_b_input,
    input wire logic [NSRC-1:0] int_request,
    input wire logic return_from_interrupt,
    input wire logic instr_done,
    output logic service_call,
    output logic [IW-1:0] service_vector,
    output logic irq
);
    // Internal source 0 and 2 are replaced by the two external inputs.
    logic [1:0] ext_irq_config_reg;
    logic [1:0] sense_reg;
    logic [NSRC-1:0] priority_reg_base;
    logic [NSRC-1:0] enable_reg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [3:0] run_count;
    eiprl_pkg::eiprl_state_t state;
    logic [IW-1:0] call_vector;
    logic low_active;
    logic high_active;
    logic irq_a_pending;
    logic irq_b_pending;
    logic edge_a;
    logic edge_b;
    logic found;
    logic found_high;
    logic [IW-1:0] win_index;
    logic [NSRC-1:0] all_request;
    logic [NSRC-1:0] eligible;
    logic wr;
    logic rd;
    logic timer_control_reg_wr;
    logic ack_a;
    logic ack_b;
    logic [1:0] event_set;
    logic [31:0] rd_value;
    logic rd_err;

    logic [1:0] next_ext_irq_config_reg;
    logic [1:0] next_sense_reg;
    logic [NSRC-1:0] next_priority_reg_base;
    logic [NSRC-1:0] next_enable_reg;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    eiprl_pkg::eiprl_state_t next_state;
    logic [3:0] next_run_count;
    logic [IW-1:0] next_call_vector;
    logic next_low_active;
    logic next_high_active;
    logic next_service_call;
    logic [IW-1:0] next_service_vector;

    // -------------------------------------------------------------------
    // External inputs and arbitration.
    // -------------------------------------------------------------------
    assign wr = psel && penable && pwrite && !pready;
    assign rd = psel && penable && !pwrite && !pready;
    assign timer_control_reg_wr = wr && (paddr == eiprl_pkg::ADDR_TIMER_CONTROL);
    assign ack_a = next_service_call && (next_service_vector == '0);
    assign ack_b = next_service_call && (next_service_vector == IW'(2));

    eiprl_ext_input u_in_a
    (
        .core_clk(core_clk),
        .srst(srst),
        .pin(ext_irq_a_input),
        .polarity(ext_irq_config_reg[eiprl_pkg::CFG_A_POL_BIT]),
        .sense_select(sense_reg[0]),
        .vector_ack(ack_a),
        .sw_write(timer_control_reg_wr),
        .sw_value(pwdata[eiprl_pkg::TIMER_CONTROL_REG_A_PEND_BIT]),
        .pending(irq_a_pending),
        .edge_event(edge_a)
    );

    eiprl_ext_input u_in_b
    (
        .core_clk(core_clk),
        .srst(srst),
        .pin(ext_irq_b_input),
        .polarity(ext_irq_config_reg[eiprl_pkg::CFG_B_POL_BIT]),
        .sense_select(sense_reg[1]),
        .vector_ack(ack_b),
        .sw_write(timer_control_reg_wr),
        .sw_value(pwdata[eiprl_pkg::TIMER_CONTROL_REG_B_PEND_BIT]),
        .pending(irq_b_pending),
        .edge_event(edge_b)
    );

    // Requests that may preempt: none while high runs, only high while low runs.
    always_comb
    begin
        all_request = int_request & enable_reg;
        // An edge is offered in the cycle it is seen, so both senses answer alike.
        all_request[0] = (irq_a_pending || edge_a) && enable_reg[0];
        all_request[2] = (irq_b_pending || edge_b) && enable_reg[2];
        eligible = all_request;
        if (high_active)
        begin
            eligible = '0;
        end
        else if (low_active)
        begin
            eligible = all_request & priority_reg_base;
        end
    end

    eiprl_arbiter #(.NSRC(NSRC)) u_arb
    (
        .request(eligible),
        .high_prio(priority_reg_base),
        .found(found),
        .found_high(found_high),
        .index(win_index)
    );

    // -------------------------------------------------------------------
    // Latency sequencer.
    // -------------------------------------------------------------------
    // Detection takes one cycle, then the call takes four; a return takes
    // five and one more instruction must finish before the next call.
    always_comb
    begin
        next_state = state;
        next_run_count = run_count;
        next_call_vector = call_vector;
        next_low_active = low_active;
        next_high_active = high_active;
        next_service_call = 1'b0;
        next_service_vector = service_vector;
        unique case (state)
            eiprl_pkg::EIPRL_IDLE:
            begin
                if (return_from_interrupt)
                begin
                    next_state = eiprl_pkg::EIPRL_RET;
                    next_run_count = eiprl_pkg::RETURN_CYCLES - 4'h1;
                end
                else if (found)
                begin
                    next_state = eiprl_pkg::EIPRL_CALL;
                    next_run_count = eiprl_pkg::CALL_CYCLES;
                    next_call_vector = win_index;
                    if (found_high)
                    begin
                        next_high_active = 1'b1;
                    end
                    else
                    begin
                        next_low_active = 1'b1;
                    end
                end
            end
            eiprl_pkg::EIPRL_CALL:
            begin
                if (run_count == 4'h1)
                begin
                    next_state = eiprl_pkg::EIPRL_IDLE;
                    next_service_call = 1'b1;
                    next_service_vector = call_vector;
                end
                next_run_count = run_count - 4'h1;
            end
            eiprl_pkg::EIPRL_RET:
            begin
                if (run_count == 4'h1)
                begin
                    next_state = eiprl_pkg::EIPRL_NEXT;
                    if (high_active)
                    begin
                        next_high_active = 1'b0;
                    end
                    else
                    begin
                        next_low_active = 1'b0;
                    end
                end
                next_run_count = run_count - 4'h1;
            end
            eiprl_pkg::EIPRL_NEXT:
            begin
                // A divide here stretches the wait to its own eight cycles.
                if (instr_done)
                begin
                    next_state = eiprl_pkg::EIPRL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state <= eiprl_pkg::EIPRL_IDLE;
            run_count <= 4'h0;
            call_vector <= '0;
            low_active <= 1'b0;
            high_active <= 1'b0;
            service_call <= 1'b0;
            service_vector <= '0;
        end
        else
        begin
            state <= next_state;
            run_count <= next_run_count;
            call_vector <= next_call_vector;
            low_active <= next_low_active;
            high_active <= next_high_active;
            service_call <= next_service_call;
            service_vector <= next_service_vector;
        end
    end

    // -------------------------------------------------------------------
    // APB registers and interrupt status.
    // -------------------------------------------------------------------
    assign event_set = {edge_b, edge_a};

    always_comb
    begin
        rd_err = 1'b0;
        rd_value = 32'h0000_0000;
        unique case (paddr)
            eiprl_pkg::ADDR_CONFIG: rd_value[1:0] = ext_irq_config_reg;
            eiprl_pkg::ADDR_TIMER_CONTROL:
            begin
                rd_value[eiprl_pkg::TIMER_CONTROL_REG_A_SENSE_BIT] = sense_reg[0];
                rd_value[eiprl_pkg::TIMER_CONTROL_REG_A_PEND_BIT] = irq_a_pending;
                rd_value[eiprl_pkg::TIMER_CONTROL_REG_B_SENSE_BIT] = sense_reg[1];
                rd_value[eiprl_pkg::TIMER_CONTROL_REG_B_PEND_BIT] = irq_b_pending;
            end
            eiprl_pkg::ADDR_PRIORITY: rd_value[NSRC-1:0] = priority_reg_base;
            eiprl_pkg::ADDR_ENABLE: rd_value[NSRC-1:0] = enable_reg;
            eiprl_pkg::ADDR_STATUS: rd_value[5:0] = {call_vector, high_active, low_active, 1'b0};
            eiprl_pkg::ADDR_IRQ_STATUS: rd_value[1:0] = irq_status;
            eiprl_pkg::ADDR_IRQ_MASK: rd_value[1:0] = irq_mask;
            default: rd_err = 1'b1;
        endcase
    end

    always_comb
    begin
        next_ext_irq_config_reg = ext_irq_config_reg;
        next_sense_reg = sense_reg;
        next_priority_reg_base = priority_reg_base;
        next_enable_reg = enable_reg;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_pready = wr || rd;
        next_pslverr = (wr || rd) && rd_err;
        next_prdata = rd ? rd_value : 32'h0000_0000;
        if (wr)
        begin
            unique case (paddr)
                eiprl_pkg::ADDR_CONFIG: next_ext_irq_config_reg = pwdata[1:0];
                eiprl_pkg::ADDR_TIMER_CONTROL:
                    next_sense_reg = {pwdata[eiprl_pkg::TIMER_CONTROL_REG_B_SENSE_BIT],
                                      pwdata[eiprl_pkg::TIMER_CONTROL_REG_A_SENSE_BIT]};
                eiprl_pkg::ADDR_PRIORITY: next_priority_reg_base = pwdata[NSRC-1:0];
                eiprl_pkg::ADDR_ENABLE: next_enable_reg = pwdata[NSRC-1:0];
                eiprl_pkg::ADDR_IRQ_STATUS: next_irq_status = irq_status & ~pwdata[1:0];
                eiprl_pkg::ADDR_IRQ_MASK: next_irq_mask = pwdata[1:0];
                default: next_irq_mask = irq_mask;
            endcase
        end
        // A new edge beats a write-one clear in the same cycle.
        next_irq_status = next_irq_status | event_set;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ext_irq_config_reg <= 2'h0;
            sense_reg <= 2'h0;
            priority_reg_base <= eiprl_pkg::PRIORITY_RESET;
            enable_reg <= '0;
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ext_irq_config_reg <= next_ext_irq_config_reg;
            sense_reg <= next_sense_reg;
            priority_reg_base <= next_priority_reg_base;
            enable_reg <= next_enable_reg;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end
endmodule

/* verilog/eiprl_pkg.sv */
// Package of constants for the external interrupt and priority logic.
package eiprl_pkg;

    // -------------------------------------------------------------------
    // Register byte offsets on the APB slave.
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_PRIORITY = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // -------------------------------------------------------------------
    // Field positions.
    // -------------------------------------------------------------------
    localparam int CFG_A_POL_BIT = 0;
    localparam int CFG_B_POL_BIT = 1;
    localparam int TIMER_CONTROL_REG_A_SENSE_BIT = 0;
    localparam int TIMER_CONTROL_REG_A_PEND_BIT = 1;
    localparam int TIMER_CONTROL_REG_B_SENSE_BIT = 2;
    localparam int TIMER_CONTROL_REG_B_PEND_BIT = 3;
    localparam int EVT_VECTOR_BIT = 0;
    localparam int EVT_RETURN_BIT = 1;

    // -------------------------------------------------------------------
    // Reset values and latency counts.
    // -------------------------------------------------------------------
    localparam logic [7:0] PRIORITY_RESET = 8'h00;
    localparam logic [3:0] CALL_CYCLES = 4'h4;
    localparam logic [3:0] RETURN_CYCLES = 4'h5;
    localparam logic [3:0] AFTER_RETURN_CYCLES = 4'h1;

    // Sequencer states.
    typedef enum logic [1:0]
    {
        EIPRL_IDLE = 2'b00,
        EIPRL_CALL = 2'b01,
        EIPRL_RET = 2'b10,
        EIPRL_NEXT = 2'b11
    } eiprl_state_t;

endpackage

/* verilog/eiprl_ext_input.sv */
// One external interrupt input with polarity, sense select and pending flag.
`timescale 1ns/100ps
module eiprl_ext_input
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic pin,
    input wire logic polarity,
    input wire logic sense_select,
    input wire logic vector_ack,
    input wire logic sw_write,
    input wire logic sw_value,
    output logic pending,
    output logic edge_event
);
    logic prev_active;
    logic edge_flag;
    logic next_prev_active;
    logic next_edge_flag;
    logic active;

    // -------------------------------------------------------------------
    // Detection.
    // -------------------------------------------------------------------
    // The pin is only read, so any peripheral on it keeps driving it.
    assign active = (pin == polarity);
    assign edge_event = active && !prev_active && sense_select;
    assign pending = sense_select ? edge_flag : active;

    // Edge flag: a new edge wins over the vector clear and the write.
    always_comb
    begin
        next_prev_active = active;
        next_edge_flag = edge_flag;
        if (sw_write)
        begin
            next_edge_flag = sw_value;
        end
        if (vector_ack)
        begin
            next_edge_flag = 1'b0;
        end
        if (edge_event)
        begin
            next_edge_flag = 1'b1;
        end
        if (!sense_select)
        begin
            next_edge_flag = 1'b0;
        end
    end

    // Registers.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prev_active <= 1'b0;
            edge_flag <= 1'b0;
        end
        else
        begin
            prev_active <= next_prev_active;
            edge_flag <= next_edge_flag;
        end
    end
endmodule

/* verilog/eiprl_arbiter.sv */
// Fixed order arbiter that picks the highest priority pending source.
`timescale 1ns/100ps
module eiprl_arbiter
#(
    parameter int NSRC = 8
)
(
    input wire logic [NSRC-1:0] request,
    input wire logic [NSRC-1:0] high_prio,
    output logic found,
    output logic found_high,
    output logic [$clog2(NSRC)-1:0] index
);
    // -------------------------------------------------------------------
    // Selection.
    // -------------------------------------------------------------------
    // High requests are tried first; inside a level the lowest index wins.
    always_comb
    begin
        found = 1'b0;
        found_high = 1'b0;
        index = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (request[i] && !high_prio[i])
            begin
                found = 1'b1;
                index = i[$clog2(NSRC)-1:0];
            end
        end
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (request[i] && high_prio[i])
            begin
                found = 1'b1;
                found_high = 1'b1;
                index = i[$clog2(NSRC)-1:0];
            end
        end
    end
endmodule

/* tb/eiprl_top_asserts.sv */
// Port-level checks for the interrupt priority block, bound to its top.
`timescale 1ns/100ps
module eiprl_top_asserts
#(
    parameter int NSRC = 8,
    parameter int IW = 3
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic return_from_interrupt,
    input wire logic instr_done,
    input wire logic service_call,
    input wire logic [IW-1:0] service_vector
);
    // -------------------------------------------------
    // Helper state
    // -------------------------------------------------
    logic ret_wait;
    logic next_ret_wait;

    // Open from a return until the instruction after it ends; a call in
    // that gap would skip the one instruction the core must run.
    always_comb
    begin
        next_ret_wait = ret_wait;
        if (srst)
            next_ret_wait = 1'b0;
        else if (return_from_interrupt)
            next_ret_wait = 1'b1;
        else if (instr_done)
            next_ret_wait = 1'b0;
    end

    // Register the window flag.
    always_ff @(posedge core_clk)
    begin
        ret_wait <= next_ret_wait;
    end

    // -------------------------------------------------
    // Properties
    // -------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // A long call occupies four cycles, so calls never sit closer.
    sequence call_gap_s;
        !service_call [*3];
    endsequence

    // The return itself takes five cycles with no call inside.
    sequence ret_hold_s;
        !service_call [*5];
    endsequence

    call_gap_a: assert property (service_call |=> call_gap_s)
        else $error("service calls closer than a long call");
    ret_hold_a: assert property (return_from_interrupt |=> ret_hold_s)
        else $error("call during return");
    ret_wait_a: assert property (ret_wait |-> !service_call)
        else $error("call before instruction after return");
    vec_hold_a: assert property (!service_call |-> $stable(service_vector))
        else $error("vector changed without a call");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_resp_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered in one cycle");
    ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access phase");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
endmodule
bind eiprl_top eiprl_top_asserts #(.NSRC(NSRC), .IW(IW)) eiprl_top_asserts_inst
(
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .return_from_interrupt(return_from_interrupt), .instr_done(instr_done),
    .service_call(service_call), .service_vector(service_vector)
);

/* tb/eiprl_src_model.sv */
// Behavioural model of the two external interrupt sources on port pins.
`timescale 1ns/100ps
module eiprl_src_model
(
    input wire logic core_clk,
    input wire logic [1:0] raise,
    input wire logic [1:0] drop,
    input wire logic [1:0] pol,
    input wire logic service_call,
    input wire logic [2:0] service_vector,
    output logic ext_irq_a_input,
    output logic ext_irq_b_input
);
    logic [1:0] active = 2'b00;

    // A source holds its request until the call to its routine is seen,
    // then withdraws at once so no second request follows.
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if ((raise[i] || active[i]) && !drop[i])
                active[i] <= !(service_call && service_vector == 3'(2 * i));
            else
                active[i] <= 1'b0;
        end
    end

    // An idle pin sits at the inverse of the active level.
    assign ext_irq_a_input = active[0] ? pol[0] : ~pol[0];
    assign ext_irq_b_input = active[1] ? pol[1] : ~pol[1];
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the external interrupt and priority block.
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_irq_a_input;
    logic ext_irq_b_input;
    logic [7:0] int_request = 8'h00;
    logic return_from_interrupt = 1'b0;
    logic instr_done = 1'b0;
    logic service_call;
    logic [2:0] service_vector;
    logic irq;
    logic [1:0] raise = 2'b00;
    logic [1:0] drop = 2'b00;
    logic [1:0] pol = 2'b00;
    logic [31:0] rdata;
    logic [31:0] sb;
    logic last_err;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    // -------------------------------------------------
    // Clock, design and far side
    // -------------------------------------------------
    always #20 core_clk = ~core_clk;

    eiprl_top eiprl_top_inst
    (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_a_input(ext_irq_a_input),
        .ext_irq_b_input(ext_irq_b_input), .int_request(int_request),
        .return_from_interrupt(return_from_interrupt), .instr_done(instr_done),
        .service_call(service_call), .service_vector(service_vector), .irq(irq)
    );

    eiprl_src_model eiprl_src_model_inst
    (
        .core_clk(core_clk), .raise(raise), .drop(drop), .pol(pol),
        .service_call(service_call), .service_vector(service_vector),
        .ext_irq_a_input(ext_irq_a_input), .ext_irq_b_input(ext_irq_b_input)
    );

    // -------------------------------------------------
    // Tasks
    // -------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an idle cycle follows so no signal is driven twice
    // in one step when transfers are chained.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdata, e);
    endtask

    // Outputs are compared mid-cycle, where they have settled.
    task automatic look(input logic v, input logic e);
        @(negedge core_clk);
        check(32'(v), 32'(e));
        @(posedge core_clk);
    endtask

    task automatic wait_call(input int lim);
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (service_call !== 1'b1 && n < lim);
    endtask

    // Return, then the following instruction lasting dly cycles.
    task automatic do_ret(input int dly);
        return_from_interrupt <= 1'b1;
        @(posedge core_clk);
        return_from_interrupt <= 1'b0;
        repeat (3 + dly) @(posedge core_clk);
        instr_done <= 1'b1;
        @(posedge core_clk);
        instr_done <= 1'b0;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rdc(eiprl_pkg::ADDR_CONFIG, 32'h0);
        rdc(eiprl_pkg::ADDR_TIMER_CONTROL, 32'h0);
        rdc(eiprl_pkg::ADDR_PRIORITY, 32'(eiprl_pkg::PRIORITY_RESET));
        rdc(8'h1c, 32'h0);
        check(32'(last_err), 32'h1);
        // Every polarity and sense mode on both pins, with calls disabled.
        for (int s = 0; s < 2; s++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                pol <= 2'(m[0]) << s;
                sb = 32'(m[1]) << (2 * s);
                wr(eiprl_pkg::ADDR_CONFIG, 32'(m[0]) << s);
                wr(eiprl_pkg::ADDR_TIMER_CONTROL, sb);
                wr(eiprl_pkg::ADDR_IRQ_STATUS, 32'h3);
                rdc(eiprl_pkg::ADDR_TIMER_CONTROL, sb);
                raise[s] <= 1'b1;
                @(posedge core_clk);
                raise[s] <= 1'b0;
                repeat (3) @(posedge core_clk);
                rdc(eiprl_pkg::ADDR_TIMER_CONTROL, sb | (32'h2 << (2 * s)));
                drop[s] <= 1'b1;
                @(posedge core_clk);
                drop[s] <= 1'b0;
                repeat (3) @(posedge core_clk);
                rdc(eiprl_pkg::ADDR_TIMER_CONTROL, sb * 3);
                if (m[1])
                begin
                    rdc(eiprl_pkg::ADDR_IRQ_STATUS, 32'h1 << s);
                    look(irq, 1'b0);
                    wr(eiprl_pkg::ADDR_IRQ_MASK, 32'h3);
                    look(irq, 1'b1);
                    wr(eiprl_pkg::ADDR_IRQ_MASK, 32'h0);
                end
                wr(eiprl_pkg::ADDR_IRQ_STATUS, 32'h3);
                look(irq, 1'b0);
            end
        end
        // Fastest response from an idle core, level then edge sensing.
        pol <= 2'b01;
        wr(eiprl_pkg::ADDR_CONFIG, 32'h1);
        wr(eiprl_pkg::ADDR_TIMER_CONTROL, 32'h0);
        wr(eiprl_pkg::ADDR_ENABLE, 32'h1);
        for (int e = 0; e < 2; e++)
        begin
            wr(eiprl_pkg::ADDR_TIMER_CONTROL, 32'(e));
            raise[0] <= 1'b1;
            @(posedge core_clk);
            raise[0] <= 1'b0;
            wait_call(40);
            check(32'(n), 32'd6);
            check(service_vector, 32'h0);
            rdc(eiprl_pkg::ADDR_TIMER_CONTROL, 32'(e));
            do_ret(2);
        end
        // Priority levels, preemption and waiting behind a running routine.
        wr(eiprl_pkg::ADDR_ENABLE, 32'h7a);
        wr(eiprl_pkg::ADDR_PRIORITY, 32'h18);
        int_request <= 8'h0a;
        wait_call(40);
        check(service_vector, 32'h3);
        int_request <= 8'h12;
        wait_call(20);
        check(32'(n), 32'd20);
        do_ret(2);
        wait_call(40);
        check(service_vector, 32'h4);
        int_request <= 8'h02;
        do_ret(2);
        wait_call(40);
        check(service_vector, 32'h1);
        int_request <= 8'h60;
        wait_call(20);
        check(32'(n), 32'd20);
        int_request <= 8'h70;
        wait_call(40);
        check(service_vector, 32'h4);
        int_request <= 8'h60;
        do_ret(2);
        wait_call(20);
        check(32'(n), 32'd20);
        do_ret(2);
        wait_call(40);
        check(service_vector, 32'h5);
        int_request <= 8'h40;
        do_ret(8);
        wait_call(40);
        check(service_vector, 32'h6);
        check(32'(12 + n), 32'd18);
        int_request <= 8'h00;
        do_ret(2);
        complete_run();
    end
endmodule
